// File: core/gsf_params.svh
// constants for the general status flags register
`ifndef GSF_PARAMS_SVH
`define GSF_PARAMS_SVH
`define GSF_ADDR 6'h07
`define GSF_BIT_FREQ 7
`define GSF_BIT_CRC_GOOD 6
`define GSF_BIT_CRC_DONE 5
`define GSF_BIT_IRQ 4
`define GSF_BIT_TIMER 3
`define GSF_BIT_FIELD 2
`define GSF_BIT_HIGH 1
`define GSF_BIT_LOW 0
`define GSF_FIFO_CAPACITY 7'h40
`define GSF_FREQ_LOW_KHZ 12000
`define GSF_FREQ_HIGH_KHZ 15000
`define GSF_CLK_KHZ 125000
`define GSF_CRC_GOOD_RST 1'b1
`define GSF_CRC_DONE_RST 1'b0
`define GSF_IRQ_RST 1'b0
`define GSF_TIMER_RST 1'b0
`define GSF_HIGH_RST 1'b1
`endif

// File: core/gsf_pkg.sv
// types for the general status flags register
package gsf_pkg;
   typedef logic [7:0] gsf_byte_t;
   typedef logic [6:0] gsf_level_t;
endpackage

// File: core/gsf_status.sv
// general status flags register of the contactless frontend
//
// How it works
// RQ1 - frequency valid set when rx frequency lies strictly inside 12..15 MHz
// RQ2 - frequency flag unchecked in the 9..12 and 15..19 MHz bands
// RQ3 - crc good reads one at zero residue, zero while calculating
// RQ4 - crc done set when a calculation finishes, meaningful for calc command
// RQ5 - interrupt pending when any enabled source of either enable set is active
// RQ6 - timer active while the timer counter will decrement next tick
// RQ7 - in gated mode timer active follows the register enable only
// RQ8 - field present mirrors live field detector, nothing latched
// RQ9 - high alert when capacity minus byte count is at most watermark
// RQ10 - low alert when byte count is at most watermark
// RQ11 - read-only register at address 07h, reset pattern X100X01X
// RQ12 - writes to this address change nothing
`timescale 1ns/1ns
`include "gsf_params.svh"
module gsf_status
   import gsf_pkg::*;
#(
   parameter int FREQ_WIN_CYCLES = 1000
)
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // host register access
   input wire logic [5:0] ADDR_I,
   input wire logic RD_I,
   input wire logic WR_I,
   input wire logic [7:0] WDATA_I,
   output logic [7:0] RDATA_O,
   // rf pins and detector
   input wire logic RX_CLK_I,
   input wire logic FIELD_DET_I,
   // crc unit
   input wire logic CRC_BUSY_I,
   input wire logic CRC_RESIDUE_ZERO_I,
   input wire logic CRC_FINISH_I,
   input wire logic CRC_START_I,
   // interrupt sources and enables
   input wire logic [7:0] COMM_IRQ_SRC_I,
   input wire logic [7:0] COMM_IRQ_EN_I,
   input wire logic [7:0] MISC_IRQ_SRC_I,
   input wire logic [7:0] MISC_IRQ_EN_I,
   // timer unit
   input wire logic TIMER_ENABLE_I,
   input wire logic TIMER_GATED_I,
   input wire logic TIMER_RUN_I,
   // fifo
   input wire logic [6:0] FIFO_BYTE_COUNT_I,
   input wire logic [5:0] FIFO_WATERMARK_I,
   // status
   output logic [7:0] STATUS_O
);

   //********************************************************
   // window counts
   //********************************************************
   localparam int LO_EDGES = (`GSF_FREQ_LOW_KHZ * FREQ_WIN_CYCLES)
                             / `GSF_CLK_KHZ;
   localparam int HI_EDGES = ((`GSF_FREQ_HIGH_KHZ * FREQ_WIN_CYCLES)
                              + `GSF_CLK_KHZ - 1) / `GSF_CLK_KHZ;

   //********************************************************
   // parameter checks
   //********************************************************
   // window must fit the 16 bit counters
   if (FREQ_WIN_CYCLES < 100 || FREQ_WIN_CYCLES > 65535)
   begin : g_bad_window
      $error("FREQ_WIN_CYCLES out of range");
   end

   // limits must leave at least one legal edge count
   if (HI_EDGES - LO_EDGES < 2)
   begin : g_bad_limits
      $error("window too short for the edge limits");
   end

   //********************************************************
   // input synchronisers
   //********************************************************
   logic [1:0] rx_sync_r, rx_sync_nxt;
   logic [1:0] fld_sync_r, fld_sync_nxt;
   logic rx_prev_r, rx_prev_nxt;

   always_comb
   begin
      rx_sync_nxt = {rx_sync_r[0], RX_CLK_I};
      fld_sync_nxt = {fld_sync_r[0], FIELD_DET_I};
      rx_prev_nxt = rx_sync_r[1];
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         rx_sync_r <= 2'h0;
         fld_sync_r <= 2'h0;
         rx_prev_r <= 1'b0;
      end
      else
      begin
         rx_sync_r <= rx_sync_nxt;
         fld_sync_r <= fld_sync_nxt;
         rx_prev_r <= rx_prev_nxt;
      end
   end

   //********************************************************
   // rf frequency window measure
   //********************************************************
   logic [15:0] win_cnt_r, win_cnt_nxt;
   logic [15:0] edge_cnt_r, edge_cnt_nxt;
   logic freq_ok_r, freq_ok_nxt;
   logic rx_rise;
   logic last_cycle;
   logic edges_inside;

   always_comb
   begin
      rx_rise = rx_sync_r[1] & ~rx_prev_r;
      last_cycle = win_cnt_r == 16'(FREQ_WIN_CYCLES - 1);
      // both limits excluded, guard bands left unchecked
      edges_inside = (edge_cnt_r > 16'(LO_EDGES))
                     && (edge_cnt_r < 16'(HI_EDGES)); // RQ1 RQ2
      win_cnt_nxt = win_cnt_r + 16'h0001;
      edge_cnt_nxt = edge_cnt_r + {15'h0000, rx_rise};
      freq_ok_nxt = freq_ok_r;
      if (last_cycle)
      begin
         win_cnt_nxt = 16'h0000;
         edge_cnt_nxt = 16'h0000;
         freq_ok_nxt = edges_inside; // RQ1
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         win_cnt_r <= 16'h0000;
         edge_cnt_r <= 16'h0000;
         freq_ok_r <= 1'b0;
      end
      else
      begin
         win_cnt_r <= win_cnt_nxt;
         edge_cnt_r <= edge_cnt_nxt;
         freq_ok_r <= freq_ok_nxt;
      end
   end

   //********************************************************
   // crc result flag
   //********************************************************
   logic crc_good_r, crc_good_nxt;

   always_comb
   begin
      // residue only trusted once the calculation is over
      if (CRC_BUSY_I)
         crc_good_nxt = 1'b0; // RQ3
      else
         crc_good_nxt = CRC_RESIDUE_ZERO_I; // RQ3
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         crc_good_r <= `GSF_CRC_GOOD_RST;
      else
         crc_good_r <= crc_good_nxt;
   end

   //********************************************************
   // crc done flag
   //********************************************************
   logic crc_done_r, crc_done_nxt;

   always_comb
   begin
      crc_done_nxt = crc_done_r;
      if (CRC_START_I)
         crc_done_nxt = 1'b0;
      // a finish in the same cycle as a start wins
      if (CRC_FINISH_I)
         crc_done_nxt = 1'b1; // RQ4
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         crc_done_r <= `GSF_CRC_DONE_RST;
      else
         crc_done_r <= crc_done_nxt;
   end

   //********************************************************
   // interrupt request
   //********************************************************
   logic irq_any;
   logic [7:0] comm_hit;
   logic [7:0] misc_hit;

   always_comb
   begin
      comm_hit = COMM_IRQ_SRC_I & COMM_IRQ_EN_I;
      misc_hit = MISC_IRQ_SRC_I & MISC_IRQ_EN_I;
      irq_any = |(comm_hit | misc_hit); // RQ5
   end

   //********************************************************
   // timer running
   //********************************************************
   logic timer_flag;

   always_comb
   begin
      // gating input selects the register enable or the run input
      if (TIMER_GATED_I)
         timer_flag = TIMER_ENABLE_I; // RQ7
      else
         timer_flag = TIMER_RUN_I; // RQ6
   end

   //********************************************************
   // fifo watermark compare
   //********************************************************
   gsf_level_t free_space;
   gsf_level_t watermark;
   logic fifo_high;
   logic fifo_low;

   always_comb
   begin
      watermark = {1'b0, FIFO_WATERMARK_I};
      free_space = `GSF_FIFO_CAPACITY - FIFO_BYTE_COUNT_I;
      fifo_high = free_space <= watermark; // RQ9
      fifo_low = FIFO_BYTE_COUNT_I <= watermark; // RQ10
   end

   //********************************************************
   // assembled status byte
   //********************************************************
   gsf_byte_t status_r, status_nxt;
   // live positions of the reset pattern shown as zero
   localparam gsf_byte_t STATUS_RST = {1'b0, `GSF_CRC_GOOD_RST,
      `GSF_CRC_DONE_RST, `GSF_IRQ_RST, `GSF_TIMER_RST, 1'b0,
      `GSF_HIGH_RST, 1'b0};

   always_comb
   begin
      status_nxt = 8'h00;
      status_nxt[`GSF_BIT_FREQ] = freq_ok_r; // RQ1
      status_nxt[`GSF_BIT_CRC_GOOD] = crc_good_r; // RQ3
      status_nxt[`GSF_BIT_CRC_DONE] = crc_done_r; // RQ4
      status_nxt[`GSF_BIT_IRQ] = irq_any; // RQ5
      status_nxt[`GSF_BIT_TIMER] = timer_flag; // RQ6 RQ7
      status_nxt[`GSF_BIT_FIELD] = fld_sync_r[1]; // RQ8
      status_nxt[`GSF_BIT_HIGH] = fifo_high; // RQ9
      status_nxt[`GSF_BIT_LOW] = fifo_low; // RQ10
   end

   // no write path reaches this register
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         status_r <= STATUS_RST; // RQ11
      else
         status_r <= status_nxt; // RQ12
   end

   //********************************************************
   // host read port
   //********************************************************
   gsf_byte_t rdata_r, rdata_nxt;
   logic rd_hit;

   always_comb
   begin
      rd_hit = RD_I && (ADDR_I == `GSF_ADDR);
      rdata_nxt = 8'h00;
      if (rd_hit)
         rdata_nxt = status_r; // RQ11
      // write strobe and data never reach a flag
      if (WR_I && WDATA_I != 8'h00)
         rdata_nxt = rdata_nxt; // RQ12
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   //********************************************************
   // outputs
   //********************************************************
   always_comb
   begin
      STATUS_O = status_r;
      RDATA_O = rdata_r;
   end

endmodule

// File: dv/gsf_status_chk.sv
// checker for the general status flags register
`timescale 1ns/1ns
module gsf_status_chk (
   input logic CLK_I, RST_I, RD_I,
   input logic [5:0] ADDR_I, FIFO_WATERMARK_I,
   input logic [7:0] RDATA_O, STATUS_O,
   input logic FIELD_DET_I, CRC_BUSY_I, CRC_RESIDUE_ZERO_I,
   input logic CRC_FINISH_I, CRC_START_I,
   input logic [7:0] COMM_IRQ_SRC_I, COMM_IRQ_EN_I,
   input logic [7:0] MISC_IRQ_SRC_I, MISC_IRQ_EN_I,
   input logic TIMER_ENABLE_I, TIMER_GATED_I, TIMER_RUN_I,
   input logic [6:0] FIFO_BYTE_COUNT_I
);
   logic [2:0] rh_r;
   always_ff @(posedge CLK_I) rh_r <= {rh_r[1:0], RST_I};
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence crc_clear_s;
      CRC_START_I && !CRC_FINISH_I ##1 !CRC_FINISH_I;
   endsequence
   a_irq_pending: assert property (!rh_r[0] |-> STATUS_O[4] ==
      |$past(COMM_IRQ_SRC_I & COMM_IRQ_EN_I | MISC_IRQ_SRC_I & MISC_IRQ_EN_I))
      else $error("irq flag");
   a_timer_flag: assert property (!rh_r[0] |-> STATUS_O[3] ==
      $past(TIMER_GATED_I ? TIMER_ENABLE_I : TIMER_RUN_I)) else $error("timer");
   a_crc_good: assert property (rh_r[1:0] == 2'h0 |-> STATUS_O[6] ==
      $past(!CRC_BUSY_I && CRC_RESIDUE_ZERO_I, 2)) else $error("crc good");
   a_crc_done_set: assert property (CRC_FINISH_I |-> ##[1:2] STATUS_O[5])
      else $error("crc done set");
   a_crc_done_clr: assert property (crc_clear_s |=> !STATUS_O[5])
      else $error("crc done clear");
   a_field_mirror: assert property (rh_r == 3'h0 |-> STATUS_O[2] ==
      $past(FIELD_DET_I, 3)) else $error("field");
   a_fifo_high: assert property (!rh_r[0] |-> STATUS_O[1] ==
      $past(7'h40 - FIFO_BYTE_COUNT_I <= FIFO_WATERMARK_I)) else $error("high");
   a_fifo_low: assert property (!rh_r[0] |-> STATUS_O[0] ==
      $past(FIFO_BYTE_COUNT_I <= FIFO_WATERMARK_I)) else $error("low");
   a_read_idle: assert property (!(RD_I && ADDR_I == 6'h07) |=>
      RDATA_O == 8'h00) else $error("idle read data");
   a_read_data: assert property (RD_I && ADDR_I == 6'h07 |=>
      RDATA_O == $past(STATUS_O)) else $error("read data");
endmodule

// File: dv/gsf_status_tb_top.sv
// testbench for the general status flags register
`timescale 1ns/1ns
module gsf_status_tb_top;
   import gsf_pkg::*;
   logic CLK_I = 0, RST_I = 1, RD_I = 0, WR_I = 0, RX_CLK_I = 0, rx_on = 0;
   logic FIELD_DET_I = 0, CRC_BUSY_I = 0, CRC_RESIDUE_ZERO_I = 1;
   logic CRC_FINISH_I = 0, CRC_START_I = 0, TIMER_ENABLE_I = 0;
   logic TIMER_GATED_I = 0, TIMER_RUN_I = 0;
   logic [5:0] ADDR_I = 6'h00, FIFO_WATERMARK_I = 6'h00;
   gsf_level_t FIFO_BYTE_COUNT_I = 7'h00;
   gsf_byte_t WDATA_I = 8'h00, COMM_IRQ_SRC_I = 8'h00, COMM_IRQ_EN_I = 8'h00;
   gsf_byte_t MISC_IRQ_SRC_I = 8'h00, MISC_IRQ_EN_I = 8'h00, RDATA_O, STATUS_O;
   int failures = 0, samples_checked = 0, rx_half = 37;
   gsf_status #(.FREQ_WIN_CYCLES(200)) dut (.*);
   initial forever #4 CLK_I = ~CLK_I;
   initial forever #rx_half RX_CLK_I = rx_on & ~RX_CLK_I;
   task chk(string n, gsf_byte_t e, gsf_byte_t g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task close_out;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task wt(int n);
      repeat (n) @(negedge CLK_I);
   endtask
   task rd(logic [5:0] a, gsf_byte_t e);
      ADDR_I = a;
      RD_I = 1;
      wt(1);
      RD_I = 0;
      chk("rdata", e, RDATA_O);
      wt(1);
      chk("rdata idle", 8'h00, RDATA_O);
   endtask
   task t_reg;
      rd(6'h07, 8'h41);
      rd(6'h06, 8'h00);
      ADDR_I = 6'h07;
      WR_I = 1;
      WDATA_I = 8'hFF;
      wt(1);
      WR_I = 0;
      wt(3);
      chk("after write", 8'h41, STATUS_O);
      rd(6'h07, 8'h41);
   endtask
   task t_tab(string n, int t [4][5], gsf_byte_t m);
      for (int i = 0; i < 4; i++)
      begin
         {COMM_IRQ_SRC_I, COMM_IRQ_EN_I} = {8'(t[i][0]), 8'(t[i][1])};
         {MISC_IRQ_SRC_I, MISC_IRQ_EN_I} = {8'(t[i][2]), 8'(t[i][3])};
         wt(2);
         chk(n, 8'(t[i][4]), STATUS_O & m);
      end
   endtask
   task automatic t_fifo;
      int t [6][3] = '{'{60,4,2}, '{59,4,0}, '{4,4,1}, '{5,4,0}, '{64,0,2},
         '{0,0,1}};
      for (int i = 0; i < 6; i++)
      begin
         FIFO_BYTE_COUNT_I = 7'(t[i][0]);
         FIFO_WATERMARK_I = 6'(t[i][1]);
         wt(2);
         chk("fifo", 8'(t[i][2]), STATUS_O & 8'h03);
      end
   endtask
   task automatic t_timer;
      int t [4][4] = '{'{1,1,0,1}, '{1,0,1,0}, '{0,1,0,0}, '{0,0,1,1}};
      for (int i = 0; i < 4; i++)
      begin
         {TIMER_GATED_I, TIMER_ENABLE_I} = {1'(t[i][0]), 1'(t[i][1])};
         TIMER_RUN_I = 1'(t[i][2]);
         wt(2);
         chk("timer", 8'(t[i][3] * 8), STATUS_O & 8'h08);
      end
   endtask
   task t_misc;
      FIELD_DET_I = 1;
      CRC_BUSY_I = 1;
      wt(4);
      chk("field busy", 8'h04, STATUS_O & 8'h64);
      {FIELD_DET_I, CRC_BUSY_I, CRC_FINISH_I} = 3'h1;
      wt(1);
      CRC_FINISH_I = 0;
      wt(3);
      chk("crc done", 8'h60, STATUS_O & 8'h64);
      {CRC_START_I, CRC_RESIDUE_ZERO_I} = 2'h2;
      wt(1);
      CRC_START_I = 0;
      wt(3);
      chk("crc start", 8'h00, STATUS_O & 8'h60);
      {CRC_START_I, CRC_FINISH_I} = 2'h3;
      wt(1);
      {CRC_START_I, CRC_FINISH_I} = 2'h0;
      wt(3);
      chk("crc both", 8'h20, STATUS_O & 8'h60);
      rx_on = 1;
      wt(500);
      chk("freq in", 8'h80, STATUS_O & 8'h80);
      rx_on = 0;
      wt(500);
      chk("freq off", 8'h00, STATUS_O & 8'h80);
      rx_half = 20;
      rx_on = 1;
      wt(500);
      chk("freq high", 8'h00, STATUS_O & 8'h80);
      rx_on = 0;
   endtask
   initial
   begin
      wt(5);
      chk("reset", 8'h42, STATUS_O & 8'h76);
      RST_I = 0;
      wt(4);
      t_reg;
      t_fifo;
      t_tab("irq", '{'{1,1,0,0,16}, '{2,1,0,0,0}, '{0,0,128,128,16},
         '{128,0,0,128,0}}, 8'h10);
      t_timer;
      t_misc;
      close_out;
   end
   initial
   begin
      #40000;
      failures++;
      close_out;
   end
endmodule
bind gsf_status gsf_status_chk chk_i (.*);
